// *** inc/dac_seq_regs.vh ***
// Purpose: register offsets, field positions, reset values and timing for the dac sequencer
// Assumes: 32-bit axi4-lite data, one register per aligned word
// Notes:   definitions only
`ifndef DAC_SEQ_REGS_VH
`define DAC_SEQ_REGS_VH

// register byte offsets
`define OFS_CONTROL_STATUS_WORD 8'h00
`define OFS_SAMPLE_COUNT        8'h04
`define OFS_MEM_POINTER         8'h08
`define OFS_MEM_DATA            8'h0C
`define OFS_CHAN_DATA_BASE      8'h40
`define OFS_CHAN_DATA_LAST      8'hBC

// control_status_word fields
`define CSW_ARM                 15
`define CSW_MEMORY_SOURCE       14
`define CSW_SOFT_TRIGGER        13
`define CSW_EXT_CLOCK           12
`define CSW_TWOS_COMPLEMENT     11
`define CSW_WIDE_FORMAT         10
`define CSW_RANGE_HI            9
`define CSW_RANGE_LO            8
`define CSW_BUSY                7
`define CSW_RUNNING             6
`define CSW_OUT_ENABLED         5
`define CSW_RATE_HI             3
`define CSW_RATE_LO             0

// reset values
`define RANGE_BIPOLAR_10V       2'b00
`define RATE_RESET              4'h0

// internal update rates in hz, selector 0 to 14
`define RATE_0_HZ               50000
`define RATE_1_HZ               20000
`define RATE_2_HZ               10000
`define RATE_3_HZ               5000
`define RATE_4_HZ               2000
`define RATE_5_HZ               1000
`define RATE_6_HZ               500
`define RATE_7_HZ               200
`define RATE_8_HZ               100
`define RATE_9_HZ               50
`define RATE_10_HZ              20
`define RATE_11_HZ              10
`define RATE_12_HZ              5
`define RATE_13_HZ              2
`define RATE_14_HZ              1

// external update clock: 64 khz at most, least spacing in ns
`define EXT_MIN_PERIOD_NS       15625
`define CLK_PERIOD_NS           10
`define EXT_MIN_PERIOD_CYC      ((`EXT_MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// converter word lengths
`define BITS_NARROW             5'd16
`define BITS_WIDE               5'd18

`endif

// *** rtl/serial_word_shifter.v ***
// Purpose: shifts one converter word out msb first with its own serial clock
// Assumes: start is a one-cycle pulse given only while busy_q is low
// Notes:   sclk idles low, data changes on the falling edge
`timescale 1ns/1ps
`default_nettype none

module serial_word_shifter #(
   parameter WIDTH    = 18,
   parameter HALF_DIV = 2
) (
   // clock and reset
   input  wire             clk,
   input  wire             resetn,
   // request
   input  wire             start,
   input  wire [WIDTH-1:0] word,
   input  wire [4:0]       nbits,
   // serial side
   output reg              sclk_q,
   output reg              sdo_q,
   // status
   output reg              busy_q,
   output reg              done_q
);

   reg [WIDTH-1:0] sr_q;
   reg [4:0]       left_q;
   reg [7:0]       div_q;

   always @(posedge clk)
   begin
      if (!resetn)
      begin
         sclk_q <= 1'b0;
         sdo_q  <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         sr_q   <= {WIDTH{1'b0}};
         left_q <= 5'd0;
         div_q  <= 8'd0;
      end
      else
      begin
         done_q <= 1'b0;
         if (start && !busy_q)
         begin
            // align the frame so its first bit sits at the top
            sr_q   <= word << (WIDTH - nbits);
            sdo_q  <= word[nbits - 5'd1];
            left_q <= nbits;
            busy_q <= 1'b1;
            sclk_q <= 1'b0;
            div_q  <= 8'd0;
         end
         else if (busy_q)
         begin
            if (div_q == HALF_DIV - 1)
            begin
               div_q  <= 8'd0;
               sclk_q <= ~sclk_q;
               if (sclk_q)
               begin
                  sr_q   <= {sr_q[WIDTH-2:0], 1'b0};
                  sdo_q  <= sr_q[WIDTH-2];
                  left_q <= left_q - 5'd1;
                  if (left_q == 5'd1)
                  begin
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                  end
               end
            end
            else
               div_q <= div_q + 8'd1;
         end
      end
   end

endmodule // serial_word_shifter

`default_nettype wire

// *** rtl/multichannel_dac_update_sequencer.v ***
// Purpose: loads sixteen serial converters one after another, then updates them together
// Assumes: axi4-lite master keeps to one write and one read at a time
// Notes:   update ticks that arrive while a load is under way are dropped
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dac_seq_regs.vh"

// Summary of operation
// - two output modes, register or memory, chosen by memory_source_select
// - memory mode plays stored samples for sample_count updates at update rate
// - channels load one after another, outputs change together at cycle end
// - update cycles run at up to 64 khz
// - wide format uses two data registers per channel, thirty-two in all
// - once armed, each channel word is shifted into its own converter
// - after the last channel, one common load strobe updates all outputs
// - register mode clears arm itself when the update is done
// - register mode ignores the update clock and starts when arm is set
// - internal update clock picks one of fifteen fixed rates, 50 khz to 1 hz
// - external update clock replaces internal one, at most 64 khz
// - outputs stay disabled at zero volts until the first update
// - output range resets to bipolar ten volts
// - codes are straight binary or two's complement, chosen by software
// - bipolar straight binary codes pass unchanged, 8000h is mid scale
// - unipolar straight binary codes pass unchanged, 0000h is zero
// - memory mode leaves arm set after each update
module multichannel_dac_update_sequencer #(
   parameter CLK_HZ     = 100000000,
   parameter MEM_DEPTH  = 64,
   parameter SHIFT_HALF = 2
) (
   // clock and reset
   input  wire        clk,
   input  wire        resetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // external timing
   input  wire        ext_update_clk,
   input  wire        ext_trigger,
   // converter side
   output wire        dac_sclk,
   output wire        dac_sdi,
   output reg  [15:0] dac_cs_n,
   output reg         dac_ldac_n,
   output reg         out_enable,
   output reg  [1:0]  range_sel
);

   localparam ST_IDLE  = 4'b0001;
   localparam ST_LOAD  = 4'b0010;
   localparam ST_SHIFT = 4'b0100;
   localparam ST_LATCH = 4'b1000;
   localparam PW       = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
   localparam [15:0] EXT_GAP = `EXT_MIN_PERIOD_CYC - 1;

   // control_status_word fields, sample count and memory write pointer
   reg        arm_q;
   reg        msel_q;
   reg        extclk_q;
   reg        twos_q;
   reg        wide_q;
   reg [3:0]  rate_q;
   reg        soft_trig_q;
   reg [15:0] sample_count_q;
   reg [PW-1:0] mem_wptr_q;

   // storage
   reg [15:0] chan_lo [0:15];
   reg [1:0]  chan_hi [0:15];
   reg [15:0] mem     [0:MEM_DEPTH-1];

   // bus slave state
   reg        aw_full_q;
   reg        w_full_q;
   reg [7:0]  awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;

   // sequencer state
   reg [3:0]  state_q;
   reg [3:0]  ch_q;
   reg        src_mem_q;
   reg        running_q;
   reg [15:0] done_cnt_q;
   reg [PW-1:0] play_ptr_q;
   reg        shift_start_q;
   reg [17:0] shift_word_q;
   reg [4:0]  shift_bits_q;

   // update clock
   reg [31:0] div_q;
   reg        ext_prev_q;
   reg [15:0] ext_gap_q;
   reg        tick_q;

   wire        sh_busy;
   wire        sh_done;
   wire        wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
   wire [15:0] wmask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [15:0] wval    = wdata_q[15:0];
   wire        wr_chan = (awaddr_q >= `OFS_CHAN_DATA_BASE) && (awaddr_q <= `OFS_CHAN_DATA_LAST);
   wire [4:0]  wr_idx  = awaddr_q[6:2] - 5'h10;
   wire        wr_csw  = wr_fire && (awaddr_q == `OFS_CONTROL_STATUS_WORD);
   wire        arm_set = wr_csw && wstrb_q[1] && wdata_q[`CSW_ARM];
   wire        busy    = (state_q != ST_IDLE);

   function [31:0] rate_div;
      input [3:0] sel;
      begin
         case (sel)
            4'd0:    rate_div = CLK_HZ / `RATE_0_HZ;
            4'd1:    rate_div = CLK_HZ / `RATE_1_HZ;
            4'd2:    rate_div = CLK_HZ / `RATE_2_HZ;
            4'd3:    rate_div = CLK_HZ / `RATE_3_HZ;
            4'd4:    rate_div = CLK_HZ / `RATE_4_HZ;
            4'd5:    rate_div = CLK_HZ / `RATE_5_HZ;
            4'd6:    rate_div = CLK_HZ / `RATE_6_HZ;
            4'd7:    rate_div = CLK_HZ / `RATE_7_HZ;
            4'd8:    rate_div = CLK_HZ / `RATE_8_HZ;
            4'd9:    rate_div = CLK_HZ / `RATE_9_HZ;
            4'd10:   rate_div = CLK_HZ / `RATE_10_HZ;
            4'd11:   rate_div = CLK_HZ / `RATE_11_HZ;
            4'd12:   rate_div = CLK_HZ / `RATE_12_HZ;
            4'd13:   rate_div = CLK_HZ / `RATE_13_HZ;
            default: rate_div = CLK_HZ / `RATE_14_HZ;
         endcase
      end
   endfunction

   // read mux straight from the request address
   reg [31:0] rd_val;
   reg        rd_ok;
   always @*
   begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      if (s_axi_araddr >= `OFS_CHAN_DATA_BASE && s_axi_araddr <= `OFS_CHAN_DATA_LAST)
      begin
         // low words sit at 0x40 (bit 6 set), upper bits at 0x80 (bit 6 clear)
         if (s_axi_araddr[6])
            rd_val[15:0] = chan_lo[s_axi_araddr[5:2]];
         else
            rd_val[1:0] = chan_hi[s_axi_araddr[5:2]];
      end
      else
      begin
         case (s_axi_araddr)
            `OFS_CONTROL_STATUS_WORD:
            begin
               rd_val[`CSW_ARM]             = arm_q;
               rd_val[`CSW_MEMORY_SOURCE]   = msel_q;
               rd_val[`CSW_EXT_CLOCK]       = extclk_q;
               rd_val[`CSW_TWOS_COMPLEMENT] = twos_q;
               rd_val[`CSW_WIDE_FORMAT]     = wide_q;
               rd_val[`CSW_RANGE_HI:`CSW_RANGE_LO] = range_sel;
               rd_val[`CSW_BUSY]            = busy;
               rd_val[`CSW_RUNNING]         = running_q;
               rd_val[`CSW_OUT_ENABLED]     = out_enable;
               rd_val[`CSW_RATE_HI:`CSW_RATE_LO] = rate_q;
            end
            `OFS_SAMPLE_COUNT: rd_val[15:0] = sample_count_q;
            `OFS_MEM_POINTER:  rd_val[PW-1:0] = mem_wptr_q;
            `OFS_MEM_DATA:     rd_val[15:0] = mem[mem_wptr_q];
            default:           rd_ok = 1'b0;
         endcase
      end
   end

   // axi4-lite handshakes
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h0000_0000;
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!aw_full_q)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (!w_full_q)
            s_axi_wready <= 1'b1;
         if (wr_fire)
         begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_chan || awaddr_q <= `OFS_MEM_DATA) &&
                            (awaddr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
      end
   end

   // register writes and storage
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         msel_q         <= 1'b0;
         extclk_q       <= 1'b0;
         twos_q         <= 1'b0;
         wide_q         <= 1'b0;
         range_sel      <= `RANGE_BIPOLAR_10V;
         rate_q         <= `RATE_RESET;
         soft_trig_q    <= 1'b0;
         sample_count_q <= 16'h0000;
         mem_wptr_q     <= {PW{1'b0}};
      end
      else
      begin
         soft_trig_q <= 1'b0;
         if (wr_csw)
         begin
            // mode bits only move while no load is under way
            if (wstrb_q[1] && !busy)
            begin
               msel_q    <= wdata_q[`CSW_MEMORY_SOURCE];
               extclk_q  <= wdata_q[`CSW_EXT_CLOCK];
               twos_q    <= wdata_q[`CSW_TWOS_COMPLEMENT];
               wide_q    <= wdata_q[`CSW_WIDE_FORMAT];
               range_sel <= wdata_q[`CSW_RANGE_HI:`CSW_RANGE_LO];
            end
            if (wstrb_q[1])
               soft_trig_q <= wdata_q[`CSW_SOFT_TRIGGER];
            if (wstrb_q[0] && !busy)
               rate_q <= wdata_q[`CSW_RATE_HI:`CSW_RATE_LO];
         end
         if (wr_fire && awaddr_q == `OFS_SAMPLE_COUNT)
            sample_count_q <= (sample_count_q & ~wmask) | (wval & wmask);
         if (wr_fire && awaddr_q == `OFS_MEM_POINTER)
            mem_wptr_q <= wdata_q[PW-1:0];
         if (wr_fire && awaddr_q == `OFS_MEM_DATA)
            mem_wptr_q <= (mem_wptr_q == MEM_DEPTH - 1) ? {PW{1'b0}} : mem_wptr_q + 1'b1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1)
      begin : g_chan
         always @(posedge clk)
         begin
            if (!resetn)
            begin
               chan_lo[gi] <= 16'h0000;
               chan_hi[gi] <= 2'b00;
            end
            else if (wr_fire && wr_chan && wr_idx[3:0] == gi)
            begin
               // each of the thirty-two words loads on its own
               if (!wr_idx[4])
                  chan_lo[gi] <= (chan_lo[gi] & ~wmask) | (wval & wmask);
               else if (wstrb_q[0])
                  chan_hi[gi] <= wdata_q[1:0];
            end
         end
      end
   endgenerate

   // no reset on the sample ram, contents are software owned
   always @(posedge clk)
   begin
      if (wr_fire && awaddr_q == `OFS_MEM_DATA)
         mem[mem_wptr_q] <= (mem[mem_wptr_q] & ~wmask) | (wval & wmask);
   end

   // update tick from the internal divider or the external clock
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         div_q      <= 32'd0;
         ext_prev_q <= 1'b0;
         ext_gap_q  <= 16'd0;
         tick_q     <= 1'b0;
      end
      else
      begin
         ext_prev_q <= ext_update_clk;
         tick_q     <= 1'b0;
         if (ext_gap_q != 16'd0)
            ext_gap_q <= ext_gap_q - 16'd1;
         if (extclk_q)
         begin
            div_q <= 32'd0;
            // edges closer than the 64 khz period are taken as glitches
            if (ext_update_clk && !ext_prev_q && ext_gap_q == 16'd0)
            begin
               tick_q    <= 1'b1;
               ext_gap_q <= EXT_GAP;
            end
         end
         else if (div_q >= rate_div(rate_q) - 32'd1)
         begin
            div_q  <= 32'd0;
            tick_q <= 1'b1;
         end
         else
            div_q <= div_q + 32'd1;
      end
   end

   // word for the current channel, two's complement turned to offset binary
   wire [15:0] lo_raw = src_mem_q ? mem[play_ptr_q] : chan_lo[ch_q];
   wire [1:0]  hi_raw = src_mem_q ? 2'b00 : chan_hi[ch_q];
   wire [17:0] word_w = wide_q ? {hi_raw[1] ^ twos_q, hi_raw[0], lo_raw}
                               : {2'b00, lo_raw[15] ^ twos_q, lo_raw[14:0]};

   // sequencer
   always @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q       <= ST_IDLE;
         ch_q          <= 4'd0;
         src_mem_q     <= 1'b0;
         arm_q         <= 1'b0;
         running_q     <= 1'b0;
         done_cnt_q    <= 16'd0;
         play_ptr_q    <= {PW{1'b0}};
         shift_start_q <= 1'b0;
         shift_word_q  <= 18'd0;
         shift_bits_q  <= `BITS_NARROW;
         dac_cs_n      <= 16'hFFFF;
         dac_ldac_n    <= 1'b1;
         out_enable    <= 1'b0;
      end
      else
      begin
         shift_start_q <= 1'b0;
         dac_ldac_n    <= 1'b1;
         if (wr_csw && wstrb_q[1] && !wdata_q[`CSW_ARM] && !busy)
         begin
            arm_q     <= 1'b0;
            running_q <= 1'b0;
         end
         if (arm_set)
            arm_q <= 1'b1;
         if (soft_trig_q || ext_trigger)
         begin
            if (arm_q && msel_q && !running_q && !busy)
            begin
               running_q  <= 1'b1;
               done_cnt_q <= 16'd0;
               play_ptr_q <= {PW{1'b0}};
            end
         end
         case (state_q)
            ST_IDLE:
            begin
               ch_q <= 4'd0;
               if (arm_q && !msel_q)
               begin
                  src_mem_q <= 1'b0;
                  state_q   <= ST_LOAD;
               end
               else if (arm_q && msel_q && running_q && tick_q)
               begin
                  src_mem_q <= 1'b1;
                  state_q   <= ST_LOAD;
               end
            end
            ST_LOAD:
            begin
               shift_word_q  <= word_w;
               shift_bits_q  <= wide_q ? `BITS_WIDE : `BITS_NARROW;
               shift_start_q <= 1'b1;
               dac_cs_n      <= ~(16'h0001 << ch_q);
               state_q       <= ST_SHIFT;
            end
            ST_SHIFT:
            begin
               if (sh_done)
               begin
                  dac_cs_n <= 16'hFFFF;
                  if (src_mem_q)
                     play_ptr_q <= (play_ptr_q == MEM_DEPTH - 1) ? {PW{1'b0}}
                                                                : play_ptr_q + 1'b1;
                  if (ch_q == 4'd15)
                     state_q <= ST_LATCH;
                  else
                  begin
                     ch_q    <= ch_q + 4'd1;
                     state_q <= ST_LOAD;
                  end
               end
            end
            ST_LATCH:
            begin
               dac_ldac_n <= 1'b0;
               out_enable <= 1'b1;
               state_q    <= ST_IDLE;
               if (src_mem_q)
               begin
                  // arm stays set so later triggers replay the memory
                  done_cnt_q <= done_cnt_q + 16'd1;
                  if (done_cnt_q + 16'd1 >= sample_count_q)
                     running_q <= 1'b0;
               end
               else if (!arm_set)
                  arm_q <= 1'b0;
            end
            default: state_q <= ST_IDLE;
         endcase
         // a re-arm during a register load changes nothing, except in the latch cycle, where it keeps arm set for another update
      end
   end

   serial_word_shifter #(
      .WIDTH    (18),
      .HALF_DIV (SHIFT_HALF)
   ) u_shifter (
      .clk    (clk),
      .resetn (resetn),
      .start  (shift_start_q),
      .word   (shift_word_q),
      .nbits  (shift_bits_q),
      .sclk_q (dac_sclk),
      .sdo_q  (dac_sdi),
      .busy_q (sh_busy),
      .done_q (sh_done)
   );

endmodule // multichannel_dac_update_sequencer

`default_nettype wire

// *** verification/dac_seq_properties.sv ***
// Purpose: port assertions for the dac update sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   select order is tracked in helper logic, not through a long sequence
`timescale 1ns/1ps
`default_nettype none
module dac_seq_properties (
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // write response
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // converter side
   input wire logic [15:0] dac_cs_n,
   input wire logic        dac_ldac_n,
   input wire logic        out_enable,
   input wire logic [1:0]  range_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [15:0] last_q;
   always @(posedge clk)
      if (!resetn) last_q <= 16'h7fff;
      else if (dac_cs_n != 16'hffff) last_q <= dac_cs_n;
   sequence last_frame_end; $rose(dac_cs_n[15]); endsequence
   sequence common_strobe; !dac_ldac_n ##1 dac_ldac_n; endsequence
   a_one_select: assert property ($onehot0(~dac_cs_n))
      else $error("more than one converter selected");
   a_next_channel: assert property ($fell(dac_cs_n == 16'hffff) |->
      dac_cs_n == {last_q[14:0], last_q[15]}) else $error("channel out of order");
   a_strobe_after: assert property (last_frame_end |-> ##[1:3] common_strobe)
      else $error("no common strobe after last channel");
   a_strobe_idle: assert property (!dac_ldac_n |-> dac_cs_n == 16'hffff ##1 dac_ldac_n)
      else $error("strobe overlaps a frame or is too long");
   a_enable_stays: assert property (out_enable |=> out_enable)
      else $error("outputs disabled again");
   a_enable_cause: assert property ($rose(out_enable) |-> !dac_ldac_n)
      else $error("outputs enabled without an update");
   a_reset_state: assert property ($rose(resetn) |-> range_sel == 2'b00 && !out_enable)
      else $error("wrong state after reset");
   a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
endmodule // dac_seq_properties
bind multichannel_dac_update_sequencer dac_seq_properties chk (.clk(clk), .resetn(resetn),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .dac_cs_n(dac_cs_n), .dac_ldac_n(dac_ldac_n), .out_enable(out_enable),
   .range_sel(range_sel));
`default_nettype wire

// *** verification/dac_bank_model.sv ***
// Purpose: sixteen serial converters sharing clock and data, one select each
// Assumes: data taken on rising sclk, msb first
// Notes:   only the last 18 bits of a frame are kept
`timescale 1ns/1ps
`default_nettype none
module dac_bank_model (
   // converter pins
   input wire logic        sclk,
   input wire logic        sdi,
   input wire logic [15:0] cs_n,
   input wire logic        ldac_n
);
   logic [17:0] shift_q;
   logic [17:0] held_q [16];
   logic [17:0] out_q [16];
   logic [15:0] prev_q = 16'hffff;
   always @(posedge sclk) shift_q <= {shift_q[16:0], sdi};
   // deselect ends the frame of that converter
   always @(cs_n)
   begin
      for (int k = 0; k < 16; k++)
         if (!prev_q[k] && cs_n[k]) held_q[k] = shift_q;
      prev_q = cs_n;
   end
   always @(negedge ldac_n)
      for (int k = 0; k < 16; k++) out_q[k] = held_q[k];
endmodule // dac_bank_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the dac update sequencer
// Assumes: axi4-lite master, one transfer at a time
// Notes:   external clock and trigger held low; soft trigger used instead
`timescale 1ns/1ps
`default_nettype none
`include "dac_seq_regs.vh"
module tb_top;
   logic        clk = 0, resetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd, d, lo [16], hi [16];
   logic [1:0]  bresp, rresp, rng, rs;
   logic        awr, wr, bv, arr, rv, sclk, sdi, ldac_n, oe;
   logic [15:0] cs_n;
   logic [1:0]  range_sel;
   int          fails = 0, num_checks = 0, ldac_cnt = 0, n, m, k;
   always #5 clk = ~clk;
   multichannel_dac_update_sequencer #(.CLK_HZ(1000000)) dut (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .ext_update_clk(1'b0), .ext_trigger(1'b0), .dac_sclk(sclk),
      .dac_sdi(sdi), .dac_cs_n(cs_n), .dac_ldac_n(ldac_n), .out_enable(oe),
      .range_sel(range_sel));
   dac_bank_model bank (.sclk(sclk), .sdi(sdi), .cs_n(cs_n), .ldac_n(ldac_n));
   always @(negedge ldac_n) ldac_cnt++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ready is looked at mid-cycle so the taking edge is known before it comes
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, pa, pw;
      awa <= a; wd <= v; awv <= 1; wv <= 1; bready <= 1; pa = 1; pw = 1;
      while (pa || pw)
      begin
         @(negedge clk); ta = pa && awr; tw = pw && wr;
         @(posedge clk); if (ta) begin awv <= 0; pa = 0; end
         if (tw) begin wv <= 0; pw = 0; end
      end
      do @(negedge clk); while (!bv);
      @(posedge clk); bready <= 0;
      @(posedge clk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      ara <= a; arv <= 1; rready <= 1;
      do @(negedge clk); while (!arr);
      @(posedge clk); arv <= 0;
      do @(negedge clk); while (!rv);
      v = rd; r = rresp;
      @(posedge clk); rready <= 0;
      @(posedge clk);
   endtask
   function automatic logic [31:0] expect_word(input logic [31:0] l, h, input int md);
      logic [31:0] e;
      e = (md == 2) ? {14'd0, h[1:0], l[15:0]} : {16'd0, l[15:0]};
      if (md == 1) e[15] = ~e[15];
      return e;
   endfunction
   task automatic wait_update(input int from);
      while (ldac_cnt == from) @(posedge clk);
      repeat (8) @(posedge clk);
   endtask
   initial
   begin
      repeat (50000) @(posedge clk);
      fails++;
      end_sim();
   end
   initial
   begin
      void'($urandom(61));
      repeat (6) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      axr(`OFS_CONTROL_STATUS_WORD, d, rs); chk(d[15:0], 16'h0000);
      chk(oe, 1'b0); chk(range_sel, 2'b00);
      axr(8'hfc, d, rs); chk(rs, 2'b10);
      for (m = 0; m < 3; m++)
      begin
         rng = $urandom;
         for (k = 0; k < 16; k++)
         begin
            lo[k] = $urandom; hi[k] = $urandom;
            axw(8'h40 + 8'(4 * k), lo[k]);
            axw(8'h80 + 8'(4 * k), hi[k]);
         end
         axr(8'h7c, d, rs); chk(d, {16'd0, lo[15][15:0]});
         axr(8'hbc, d, rs); chk(d, {30'd0, hi[15][1:0]});
         // 0: plain, 1: two's complement, 2: wide format
         d = 32'h0000_8000 | ((m == 1) << 11) | ((m == 2) << 10) | (rng << 8);
         n = ldac_cnt;
         axw(`OFS_CONTROL_STATUS_WORD, d);
         axw(`OFS_CONTROL_STATUS_WORD, d);
         wait_update(n);
         chk(ldac_cnt, n + 1);
         axr(`OFS_CONTROL_STATUS_WORD, d, rs); chk(d[15], 1'b0);
         chk(oe, 1'b1); chk(range_sel, rng);
         for (k = 0; k < 16; k++)
            chk(m == 2 ? bank.out_q[k] : bank.out_q[k][15:0], expect_word(lo[k], hi[k], m));
      end
      axw(`OFS_MEM_POINTER, 32'h0000_0000);
      for (k = 0; k < 16; k++)
      begin
         lo[k] = $urandom; axw(`OFS_MEM_DATA, lo[k]);
      end
      axw(`OFS_SAMPLE_COUNT, 32'h0000_0001);
      n = ldac_cnt;
      axw(`OFS_CONTROL_STATUS_WORD, 32'h0000_e000);
      wait_update(n);
      for (k = 0; k < 16; k++) chk(bank.out_q[k][15:0], lo[k][15:0]);
      axr(`OFS_CONTROL_STATUS_WORD, d, rs); chk(d[15:14], 2'b11);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
